// >>> shared/adcg3_pkg.sv
package adcg3_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] PATHPF_OFFSET = 8'h2d;
    localparam logic [7:0] INSEL_OFFSET = 8'h2f;
    localparam logic [15:0] PATHPF_RESET = 16'h0000;
    localparam logic [15:0] INSEL_RESET = 16'h0000;
    localparam int PRBS_LSB = 12;
    localparam int PAT9_LSB = 9;
    localparam int PAT10_LSB = 6;
    localparam int ROUND_BIT = 5;
    localparam int CORNER_LSB = 1;
    localparam int HPF_EN_BIT = 0;
    localparam int PAIR_LSB = 8;
    localparam int PAT11_LSB = 5;
    localparam int PAT12_LSB = 2;
    localparam logic [15:0] INSEL_WMASK = 16'h0ffc;
    localparam logic [3:0] CORNER_MIN = 4'h2;
    localparam logic [3:0] CORNER_MAX = 4'ha;
    localparam logic [3:0] CORNER_DEFAULT = 4'h2;
endpackage

// >>> core/adcg3_regs.sv
// Behaviour
// - with independent pattern select set, bits 15..12 of the first register enable prbs on outputs 9..12.
// - with independent pattern select set, bits 11-9 and 8-6 of the first register pick the pattern of outputs 9, 10.
// - with independent pattern select set, bits 7-5 and 4-2 of the second register pick the pattern of outputs 11, 12.
// - bit 5 of the first register picks rounding (1) or truncation (0) of filter output for channels 9 to 12.
// - with the filter enabled, bits 4-1 set the filter constant k, valid from 2 to 10.
// - bit 0 of the first register enables the high-pass filter for converters 9 to 12, default off.
// - in 16-input mode, bits 11..8 of the second register pick the lower (0) or higher (1) input pair of converters 9..12.
module adcg3_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [adcg3_pkg::ADDR_W-1:0] addr,
    input wire logic [adcg3_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [adcg3_pkg::DATA_W-1:0] rdata,
    input wire logic independent_pattern_select,
    input wire logic sixteen_input_mode,
    output logic [3:0] prbs_enable,
    output logic [2:0] test_pattern_sel_out9,
    output logic [2:0] test_pattern_sel_out10,
    output logic [2:0] test_pattern_sel_out11,
    output logic [2:0] test_pattern_sel_out12,
    output logic highpass_round_enable_grp,
    output logic [3:0] highpass_corner_k_grp,
    output logic highpass_enable_grp,
    output logic [3:0] input_pair_sel,
    output logic corner_invalid
);
    import adcg3_pkg::*;

    logic [15:0] ctl_q;
    logic [15:0] ctl_d;
    logic [15:0] sel_q;
    logic [15:0] sel_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic wr_ctl;
    logic wr_sel;
    logic rd_ctl;
    logic rd_sel;
    logic [3:0] prbs_raw;
    logic [3:0] pair_raw;
    logic [3:0] corner_raw;
    logic corner_bad;

    // one address compare for both strobes keeps the decode in one place
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off, input logic strobe);
        addr_hit = strobe && (a == off);
    endfunction

    function automatic logic [2:0] pat_gate(input logic [15:0] r, input int lsb, input logic ind);
        pat_gate = ind ? r[lsb +: 3] : 3'h0;
    endfunction

    // lowest channel sits at the top bit, so four-bit fields are flipped
    function automatic logic [3:0] flip4(input logic [15:0] r, input int lsb);
        flip4 = {r[lsb], r[lsb+1], r[lsb+2], r[lsb+3]};
    endfunction

    function automatic logic k_out_of_range(input logic [3:0] kv);
        k_out_of_range = (kv < CORNER_MIN) || (kv > CORNER_MAX);
    endfunction

    // unmapped addresses hit nothing: writes are lost and reads give zero
    always_comb begin
        wr_ctl = addr_hit(addr, PATHPF_OFFSET, wr);
        wr_sel = addr_hit(addr, INSEL_OFFSET, wr);
        rd_ctl = addr_hit(addr, PATHPF_OFFSET, rd);
        rd_sel = addr_hit(addr, INSEL_OFFSET, rd);
    end

    always_comb begin
        ctl_d = ctl_q;
        sel_d = sel_q;
        if (wr_ctl) begin
            ctl_d = wdata;
        end
        // reserved bits are dropped so they always read zero
        if (wr_sel) begin
            sel_d = wdata & INSEL_WMASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= PATHPF_RESET;
            sel_q <= INSEL_RESET;
        end else begin
            ctl_q <= ctl_d;
            sel_q <= sel_d;
        end
    end

    // read data live for one cycle only, zero otherwise
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_ctl) begin
            rdata_d = ctl_q;
        end else if (rd_sel) begin
            rdata_d = sel_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    always_comb begin
        prbs_raw = flip4(ctl_q, PRBS_LSB);
        pair_raw = flip4(sel_q, PAIR_LSB);
        corner_raw = ctl_q[CORNER_LSB +: 4];
        corner_bad = k_out_of_range(corner_raw);
    end

    // bit 15 maps to output 9, so bit 0 of the port is output 9
    assign prbs_enable = independent_pattern_select ? prbs_raw : 4'h0;
    assign test_pattern_sel_out9 = pat_gate(ctl_q, PAT9_LSB, independent_pattern_select);
    assign test_pattern_sel_out10 = pat_gate(ctl_q, PAT10_LSB, independent_pattern_select);
    assign test_pattern_sel_out11 = pat_gate(sel_q, PAT11_LSB, independent_pattern_select);
    assign test_pattern_sel_out12 = pat_gate(sel_q, PAT12_LSB, independent_pattern_select);
    assign highpass_round_enable_grp = ctl_q[ROUND_BIT];
    assign highpass_enable_grp = ctl_q[HPF_EN_BIT];
    // out-of-range k is clamped to the minimum rather than passed to the filter
    assign corner_invalid = corner_bad;
    assign highpass_corner_k_grp = corner_bad ? CORNER_DEFAULT : corner_raw;
    // bit 11 maps to converter 9; outside 16-input mode the lower pair is used
    assign input_pair_sel = sixteen_input_mode ? pair_raw : 4'h0;

    a_prbs_gate: assert property (@(posedge clk) disable iff (!nrst)
        !independent_pattern_select |-> prbs_enable == 4'h0)
        else $error("prbs on without select");

    a_prbs_map: assert property (@(posedge clk) disable iff (!nrst)
        independent_pattern_select |-> prbs_enable[0] == ctl_q[15] && prbs_enable[3] == ctl_q[12])
        else $error("prbs bit map wrong");

    a_prbs_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_ctl ##1 independent_pattern_select |-> prbs_enable[0] == $past(wdata[15]) && prbs_enable[3] == $past(wdata[12]))
        else $error("prbs not from write");

    a_pat_write: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == PATHPF_OFFSET ##1 independent_pattern_select |->
        test_pattern_sel_out9 == $past(wdata[11:9]) && test_pattern_sel_out10 == $past(wdata[8:6]))
        else $error("pattern 9/10 not from write");

    a_pat_second: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == INSEL_OFFSET ##1 independent_pattern_select |->
        test_pattern_sel_out11 == $past(wdata[7:5]) && test_pattern_sel_out12 == $past(wdata[4:2]))
        else $error("pattern 11/12 not from write");

    a_pattern_gate: assert property (@(posedge clk) disable iff (!nrst)
        !independent_pattern_select |-> test_pattern_sel_out9 == 3'h0 && test_pattern_sel_out12 == 3'h0)
        else $error("pattern on without select");

    a_round_bit: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == PATHPF_OFFSET |=> highpass_round_enable_grp == $past(wdata[5]))
        else $error("round bit not updated");

    a_corner_range: assert property (@(posedge clk) disable iff (!nrst)
        highpass_corner_k_grp >= 4'h2 && highpass_corner_k_grp <= 4'ha)
        else $error("k out of range");

    a_corner_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_ctl && wdata[4:1] >= 4'h2 && wdata[4:1] <= 4'ha |=> highpass_corner_k_grp == $past(wdata[4:1]))
        else $error("valid k not taken");

    a_corner_clamp: assert property (@(posedge clk) disable iff (!nrst)
        corner_invalid |-> highpass_corner_k_grp == 4'h2)
        else $error("bad k not clamped");

    a_hpf_enable: assert property (@(posedge clk) disable iff (!nrst)
        wr && addr == PATHPF_OFFSET |=> highpass_enable_grp == $past(wdata[0]))
        else $error("filter enable not updated");

    a_pair_map: assert property (@(posedge clk) disable iff (!nrst)
        sixteen_input_mode |-> input_pair_sel[0] == sel_q[11] && input_pair_sel[3] == sel_q[8])
        else $error("pair select map wrong");

    a_pair_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_sel ##1 sixteen_input_mode |-> input_pair_sel[0] == $past(wdata[11]) && input_pair_sel[3] == $past(wdata[8]))
        else $error("pair select not from write");

    a_pair_gate: assert property (@(posedge clk) disable iff (!nrst)
        !sixteen_input_mode |-> input_pair_sel == 4'h0)
        else $error("pair select outside mode");

    a_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
        rd && addr == INSEL_OFFSET |=> rdata[15:12] == 4'h0 && rdata[1:0] == 2'h0)
        else $error("reserved bits read nonzero");

    a_read_idle: assert property (@(posedge clk) disable iff (!nrst)
        !rd |=> rdata == 16'h0000)
        else $error("read data without strobe");

    a_read_ctl: assert property (@(posedge clk) disable iff (!nrst)
        rd_ctl |=> rdata == $past(ctl_q))
        else $error("control readback wrong");

    a_unmapped_write: assert property (@(posedge clk) disable iff (!nrst)
        wr && !wr_ctl && !wr_sel |=> ctl_q == $past(ctl_q) && sel_q == $past(sel_q))
        else $error("unmapped write changed state");

    c_write_read: cover property (@(posedge clk) disable iff (!nrst)
        wr && addr == PATHPF_OFFSET ##1 rd && addr == PATHPF_OFFSET);
    c_hpf_on: cover property (@(posedge clk) disable iff (!nrst) highpass_enable_grp && !corner_invalid);
    c_k_clamped: cover property (@(posedge clk) disable iff (!nrst) highpass_enable_grp && corner_invalid);
    c_prbs_all: cover property (@(posedge clk) disable iff (!nrst) prbs_enable == 4'hf);
    c_pair_high: cover property (@(posedge clk) disable iff (!nrst) input_pair_sel == 4'hf);
endmodule

// >>> testbench/adc_group3_pattern_hpf_config_tb_top.sv
module adc_group3_pattern_hpf_config_tb_top import adcg3_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, ind_sel = 1'b0, mode16 = 1'b0, rnd, hen, kbad;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [3:0] prbs, k, pair;
    logic [2:0] p9, p10, p11, p12;
    int n_mismatch = 0, checks_done = 0;
    wire logic [26:0] outs = {prbs, p9, p10, p11, p12, rnd, k, hen, pair, kbad};
    adcg3_regs dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .independent_pattern_select(ind_sel), .sixteen_input_mode(mode16), .prbs_enable(prbs),
        .test_pattern_sel_out9(p9), .test_pattern_sel_out10(p10), .test_pattern_sel_out11(p11),
        .test_pattern_sel_out12(p12), .highpass_round_enable_grp(rnd), .highpass_corner_k_grp(k),
        .highpass_enable_grp(hen), .input_pair_sel(pair), .corner_invalid(kbad));
    always #50 clk = ~clk;
    task automatic check(input logic [26:0] seen, input logic [26:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {addr, wdata} <= {a, d};
        {wr, rd} <= {w, !w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 if (!w) check({11'h000, rdata}, {11'h000, d});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #1000000 n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1 check(outs, {4'h0, 12'h000, 1'b0, 4'h2, 1'b0, 4'h0, 1'b1});
        acc(1'b0, 8'h2d, 16'h0000);
        acc(1'b0, 8'h2f, 16'h0000);
        $display("reset test done");
        @(posedge clk) {ind_sel, mode16} <= 2'b11;
        acc(1'b1, 8'h2d, 16'h8af5);
        check(outs, {4'h1, 3'h5, 3'h3, 6'h00, 1'b1, 4'ha, 1'b1, 4'h0, 1'b0});
        acc(1'b0, 8'h2d, 16'h8af5);
        acc(1'b1, 8'h2d, 16'h7004);
        check(outs, {4'he, 12'h000, 1'b0, 4'h2, 1'b0, 4'h0, 1'b0});
        acc(1'b1, 8'h2d, 16'h0017);
        check(outs, {4'h0, 12'h000, 1'b0, 4'h2, 1'b1, 4'h0, 1'b1});
        $display("control test done");
        acc(1'b1, 8'h2f, 16'hffff);
        acc(1'b0, 8'h2f, 16'h0ffc);
        acc(1'b1, 8'h2f, 16'h08a8);
        check(outs, {4'h0, 6'h00, 3'h5, 3'h2, 1'b0, 4'h2, 1'b1, 4'h1, 1'b1});
        @(posedge clk) {ind_sel, mode16} <= 2'b00;
        #1 check(outs, {4'h0, 12'h000, 1'b0, 4'h2, 1'b1, 4'h0, 1'b1});
        $display("select test done");
        acc(1'b1, 8'h2e, 16'hffff);
        acc(1'b0, 8'h2e, 16'h0000);
        acc(1'b0, 8'h2d, 16'h0017);
        $display("unmapped test done");
        end_of_test();
    end
endmodule
